// File: verilog/bst_pkg.sv
// Notes on behaviour
// - External test and sample/preload put the boundary register between data in and data out.
// - The boundary register captures input pin levels and forces held levels and drive directions on outputs.
// - Bypass routes data in through a single shift stage to data out.
// - The TAP state machine moves on each rising test clock edge, steered by the mode level sampled there.
// - The state machine has an instruction branch and a data branch for the selected data register.
// - Mode held high for five rising test clock edges reaches Test-Logic-Reset from any state.
// - The test logic is static, so the test clock may stop high or low for any time without loss.
// - With the compliance pin at 1 the TAP is held in reset and its pins serve debug mode.
// - With the compliance pin at 0 pull-ups are enabled on data in, mode and test reset.
// - The instruction register is 3 bits: extest 0, idcode 1, sample 4, highz 5, clamp 6, bypass 7.
// - Test-Logic-Reset or test reset loads idcode, and Capture-IR loads 1 into the instruction shifter.
// - A shifted instruction takes effect on the falling test clock edge in Update-IR.
// - The bypass stage loads 0 on the rising edge in Capture-DR, so the first bit out is 0.
package bst_pkg;

  localparam int unsigned BST_IR_W     = 3;
  localparam int unsigned BST_ID_W     = 32;
  localparam int unsigned BST_N_IN     = 8;
  localparam int unsigned BST_N_OUT    = 8;
  localparam int unsigned BST_TMS_RST  = 5;
  // Clocks after reset before pin edges count
  localparam logic [2:0]  BST_WARM_CYC = 3'h4;

  localparam logic [2:0] BST_IR_EXTEST  = 3'h0;
  localparam logic [2:0] BST_IR_IDCODE  = 3'h1;
  localparam logic [2:0] BST_IR_SAMPLE  = 3'h4;
  localparam logic [2:0] BST_IR_HIGHZ   = 3'h5;
  localparam logic [2:0] BST_IR_CLAMP   = 3'h6;
  localparam logic [2:0] BST_IR_BYPASS  = 3'h7;
  localparam logic [2:0] BST_IR_RESET   = BST_IR_IDCODE;
  localparam logic [2:0] BST_IR_CAPTURE = 3'h1;

  // Arbitrary identification value; bit 0 must stay 1
  localparam logic [31:0] BST_ID_VALUE  = 32'h0000_0001;

  localparam int unsigned BST_TCK_NS    = 160;
  localparam int unsigned BST_CLK_NS    = 5;
  localparam int unsigned BST_TCK_CYC   = BST_TCK_NS / BST_CLK_NS;

  typedef enum logic [15:0] {
    BST_TLR  = 16'h0001,
    BST_RTI  = 16'h0002,
    BST_SDRS = 16'h0004,
    BST_CDR  = 16'h0008,
    BST_SDR  = 16'h0010,
    BST_E1DR = 16'h0020,
    BST_PDR  = 16'h0040,
    BST_E2DR = 16'h0080,
    BST_UDR  = 16'h0100,
    BST_SIRS = 16'h0200,
    BST_CIR  = 16'h0400,
    BST_SIR  = 16'h0800,
    BST_E1IR = 16'h1000,
    BST_PIR  = 16'h2000,
    BST_E2IR = 16'h4000,
    BST_UIR  = 16'h8000
  } bst_tap_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic dbg_sel;
  } bst_tap_in_t;

  localparam int unsigned BST_TAP_IN_W = $bits(bst_tap_in_t);

endpackage

// File: verilog/bst_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module bst_sync3 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] mid_o,
  output logic      [W-1:0] last_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } bst_sync_st_t;

  bst_sync_st_t st_q;
  bst_sync_st_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign mid_o  = st_q.s2;
  assign last_o = st_q.s3;
endmodule
`default_nettype wire

// File: verilog/bst_buf2.sv
`timescale 1ns/1ps
`default_nettype none
module bst_buf2 #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              wr;
    logic              rd;
    logic [1:0]        cnt;
  } bst_buf_st_t;

  bst_buf_st_t st_q;
  bst_buf_st_t st_d;
  logic        push;
  logic        pop;

  assign in_ready  = (st_q.cnt != 2'h2);
  assign out_valid = (st_q.cnt != 2'h0);
  assign out_data  = st_q.mem[st_q.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr] = in_data;
      st_d.wr           = ~st_q.wr;
    end
    if (pop) begin
      st_d.rd = ~st_q.rd;
    end
    if (push && !pop) begin
      st_d.cnt = st_q.cnt + 2'h1;
    end else if (pop && !push) begin
      st_d.cnt = st_q.cnt - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule
`default_nettype wire

// File: verilog/bst_tap.sv
`timescale 1ns/1ps
`default_nettype none
module bst_tap
  import bst_pkg::*;
#(
  parameter int unsigned   N_IN     = BST_N_IN,
  parameter int unsigned   N_OUT    = BST_N_OUT,
  parameter logic [31:0]   ID_VALUE = BST_ID_VALUE
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire bst_tap_in_t        tap_i,
  output logic                    tdo,
  output logic                    tdo_oe_n,
  input  wire logic [N_IN-1:0]    pin_in,
  input  wire logic [N_OUT-1:0]   core_o,
  input  wire logic [N_OUT-1:0]   core_oe_n,
  output logic      [N_OUT-1:0]   pin_o,
  output logic      [N_OUT-1:0]   pin_oe_n,
  input  wire logic               upd_accept,
  output logic                    func_rst,
  output logic                    pull_en,
  output logic                    dbg_mode
);
  localparam int unsigned BS_LEN = N_IN + 2 * N_OUT;
  localparam int unsigned UPD_W  = 2 * N_OUT;

  typedef struct packed {
    bst_tap_t                   tap;
    logic [BST_IR_W-1:0]        ir;
    logic [BST_IR_W-1:0]        irs;
    logic [BS_LEN-1:0]          bsr;
    logic                       byp;
    logic [BST_ID_W-1:0]        idr;
    logic [BST_TAP_IN_W-1:0]    filt;
    logic                       pend;
    logic [UPD_W-1:0]           pend_word;
    logic [UPD_W-1:0]           held;
    logic                       tdo;
    logic                       tdo_oe_n;
    logic [N_OUT-1:0]           pin_o;
    logic [N_OUT-1:0]           pin_oe_n;
    logic                       func_rst;
    logic                       pull_en;
    logic                       dbg;
    logic [N_IN-1:0]            pin_filt;
    logic [2:0]                 warm;
  } bst_tap_st_t;

  bst_tap_st_t               st_q;
  bst_tap_st_t               st_d;
  logic [BST_TAP_IN_W-1:0]   s_mid;
  logic [BST_TAP_IN_W-1:0]   s_last;
  logic [N_IN-1:0]           pin_mid;
  logic [N_IN-1:0]           pin_last;
  logic [BST_TAP_IN_W-1:0]   agree;
  logic [BST_TAP_IN_W-1:0]   filt_nx;
  bst_tap_in_t               f_now;
  bst_tap_in_t               f_old;
  logic                      tck_rise;
  logic                      tck_fall;
  logic                      tap_rst;
  logic                      sel_bsr;
  logic                      sel_id;
  logic                      buf_in_ready;
  logic                      buf_out_valid;
  logic [UPD_W-1:0]          buf_out_data;
  logic                      buf_push;

  bst_sync3 #(
    .W (BST_TAP_IN_W)
  ) u_sync (
    .clk     (clk),
    .rst     (rst),
    .async_i (tap_i),
    .mid_o   (s_mid),
    .last_o  (s_last)
  );

  // Board pin levels are asynchronous to clk as well
  bst_sync3 #(
    .W (N_IN)
  ) u_pin_sync (
    .clk     (clk),
    .rst     (rst),
    .async_i (pin_in),
    .mid_o   (pin_mid),
    .last_o  (pin_last)
  );

  // Update words queue toward the pin side; a slow pin side delays them, and an update while one is still pending is dropped
  bst_buf2 #(
    .W (UPD_W)
  ) u_upd_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (st_q.pend),
    .in_ready  (buf_in_ready),
    .in_data   (st_q.pend_word),
    .out_valid (buf_out_valid),
    .out_ready (upd_accept),
    .out_data  (buf_out_data)
  );

  // A pin level counts only once two stages agree, which also rejects slow TCK ramps
  assign agree    = ~(s_mid ^ s_last);
  assign filt_nx  = (agree & s_mid) | (~agree & st_q.filt);
  assign f_old    = bst_tap_in_t'(st_q.filt);
  assign f_now    = bst_tap_in_t'(filt_nx);
  assign tck_rise = f_now.tck && !f_old.tck;
  assign tck_fall = !f_now.tck && f_old.tck;
  // Held through warm-up: a test clock parked high would else look like a rise
  assign tap_rst  = !f_now.trst_n || f_now.dbg_sel || (st_q.warm != BST_WARM_CYC);
  assign buf_push = st_q.pend && buf_in_ready;

  // Unused codes fall back to the bypass stage
  always_comb begin
    sel_bsr = (st_q.ir == BST_IR_EXTEST) || (st_q.ir == BST_IR_SAMPLE);
    sel_id  = (st_q.ir == BST_IR_IDCODE);
  end

  function automatic bst_tap_t tap_next(input bst_tap_t cur, input logic m);
    bst_tap_t nx;
    nx = BST_TLR;
    unique case (cur)
      BST_TLR:  nx = m ? BST_TLR  : BST_RTI;
      BST_RTI:  nx = m ? BST_SDRS : BST_RTI;
      BST_SDRS: nx = m ? BST_SIRS : BST_CDR;
      BST_CDR:  nx = m ? BST_E1DR : BST_SDR;
      BST_SDR:  nx = m ? BST_E1DR : BST_SDR;
      BST_E1DR: nx = m ? BST_UDR  : BST_PDR;
      BST_PDR:  nx = m ? BST_E2DR : BST_PDR;
      BST_E2DR: nx = m ? BST_UDR  : BST_SDR;
      BST_UDR:  nx = m ? BST_SDRS : BST_RTI;
      BST_SIRS: nx = m ? BST_TLR  : BST_CIR;
      BST_CIR:  nx = m ? BST_E1IR : BST_SIR;
      BST_SIR:  nx = m ? BST_E1IR : BST_SIR;
      BST_E1IR: nx = m ? BST_UIR  : BST_PIR;
      BST_PIR:  nx = m ? BST_E2IR : BST_PIR;
      BST_E2IR: nx = m ? BST_UIR  : BST_SIR;
      BST_UIR:  nx = m ? BST_SDRS : BST_RTI;
      default:  nx = BST_TLR;
    endcase
    return nx;
  endfunction

  always_comb begin
    st_d      = st_q;
    st_d.filt = filt_nx;
    st_d.dbg  = f_now.dbg_sel;
    st_d.pull_en = !f_now.dbg_sel;
    st_d.pin_filt = (~(pin_mid ^ pin_last) & pin_mid) | ((pin_mid ^ pin_last) & st_q.pin_filt);
    if (st_q.warm != BST_WARM_CYC) begin
      st_d.warm = st_q.warm + 3'h1;
    end

    // No timeout anywhere: a stopped TCK leaves the TAP state, instruction and scan registers as they are
    if (tck_rise) begin
      st_d.tap = tap_next(st_q.tap, f_old.tms);
      unique case (st_q.tap)
        BST_CIR: begin
          st_d.irs = BST_IR_CAPTURE;
        end
        BST_SIR: begin
          st_d.irs = {f_old.tdi, st_q.irs[BST_IR_W-1:1]};
        end
        BST_CDR: begin
          st_d.byp = 1'b0;
          st_d.idr = ID_VALUE;
          st_d.bsr = {core_oe_n, core_o, st_q.pin_filt};
        end
        BST_SDR: begin
          if (sel_bsr) begin
            st_d.bsr = {f_old.tdi, st_q.bsr[BS_LEN-1:1]};
          end else if (sel_id) begin
            st_d.idr = {f_old.tdi, st_q.idr[BST_ID_W-1:1]};
          end else begin
            st_d.byp = f_old.tdi;
          end
        end
        default: begin
        end
      endcase
    end

    if (tck_fall) begin
      unique case (st_q.tap)
        BST_UIR: begin
          st_d.ir = st_q.irs;
        end
        BST_UDR: begin
          if (sel_bsr && !st_q.pend) begin
            st_d.pend      = 1'b1;
            st_d.pend_word = st_q.bsr[BS_LEN-1:N_IN];
          end
        end
        default: begin
        end
      endcase
      if (st_q.tap == BST_SIR) begin
        st_d.tdo      = st_q.irs[0];
        st_d.tdo_oe_n = 1'b0;
      end else if (st_q.tap == BST_SDR) begin
        st_d.tdo_oe_n = 1'b0;
        if (sel_bsr) begin
          st_d.tdo = st_q.bsr[0];
        end else if (sel_id) begin
          st_d.tdo = st_q.idr[0];
        end else begin
          st_d.tdo = st_q.byp;
        end
      end else begin
        st_d.tdo_oe_n = 1'b1;
      end
    end

    if (buf_push) begin
      st_d.pend = 1'b0;
    end
    if (buf_out_valid && upd_accept) begin
      st_d.held = buf_out_data;
    end

    // Test reset and debug mode pin the TAP and park the output
    if (tap_rst) begin
      st_d.tap      = BST_TLR;
      st_d.tdo_oe_n = 1'b1;
    end
    if (st_d.tap == BST_TLR) begin
      st_d.ir = BST_IR_RESET;
    end

    unique case (st_q.ir)
      BST_IR_EXTEST, BST_IR_CLAMP: begin
        st_d.pin_o    = st_q.held[N_OUT-1:0];
        st_d.pin_oe_n = st_q.held[UPD_W-1:N_OUT];
        st_d.func_rst = 1'b1;
      end
      BST_IR_HIGHZ: begin
        st_d.pin_o    = core_o;
        st_d.pin_oe_n = '1;
        st_d.func_rst = 1'b1;
      end
      default: begin
        st_d.pin_o    = core_o;
        st_d.pin_oe_n = core_oe_n;
        st_d.func_rst = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q          <= '0;
      st_q.tap      <= BST_TLR;
      st_q.ir       <= BST_IR_RESET;
      st_q.irs      <= BST_IR_CAPTURE;
      st_q.tdo_oe_n <= 1'b1;
      st_q.pin_oe_n <= '1;
      st_q.filt     <= '0;
      st_q.pull_en  <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign tdo      = st_q.tdo;
  assign tdo_oe_n = st_q.tdo_oe_n;
  assign pin_o    = st_q.pin_o;
  assign pin_oe_n = st_q.pin_oe_n;
  assign func_rst = st_q.func_rst;
  assign pull_en  = st_q.pull_en;
  assign dbg_mode = st_q.dbg;
endmodule
`default_nettype wire

// File: sim/bst_tap_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bst_tap_checker
  import bst_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire bst_tap_in_t tap_i,
  input wire logic        tdo,
  input wire logic        tdo_oe_n,
  input wire logic        func_rst,
  input wire logic        pull_en,
  input wire logic        dbg_mode
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);

  a_rst_values: assert property (disable iff (1'b0) rst |=> tdo_oe_n && pull_en && !dbg_mode)
    else $error("reset values wrong");
  a_pull_dbg: assert property (pull_en != dbg_mode)
    else $error("pull enable disagrees with debug mode");
  a_dbg_quiet: assert property (dbg_mode [*3] |-> tdo_oe_n)
    else $error("data out driven in debug mode");
  a_dbg_func: assert property (dbg_mode [*3] |-> !func_rst)
    else $error("functional reset in debug mode");
  a_tdo_fall: assert property ($changed(tdo) |-> !tap_i.tck)
    else $error("data out changed while test clock high");
  a_oe_fall: assert property ($fell(tdo_oe_n) |-> !tap_i.tck)
    else $error("data out enabled while test clock high");
  a_trst_func: assert property (!tap_i.trst_n [*8] |-> !func_rst && tdo_oe_n)
    else $error("test reset did not restore default");
  // Eight quiet samples cover sync and filter latency
  a_static_hold: assert property ($stable(tap_i) [*8] |-> $stable({tdo, tdo_oe_n, func_rst}))
    else $error("state moved with pins quiet");

  cover property ($fell(tdo_oe_n));
  cover property ($rose(func_rst));
  cover property ($rose(dbg_mode));
endmodule

bind bst_tap bst_tap_checker i_chk (
  .clk(clk), .rst(rst), .tap_i(tap_i), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
  .func_rst(func_rst), .pull_en(pull_en), .dbg_mode(dbg_mode)
);
`default_nettype wire

// File: sim/bst_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module bst_ctl_model (
  input  wire logic  clk,
  input  wire logic  tdo,
  input  wire logic  tdo_oe_n,
  output logic       tck,
  output logic       tms,
  output logic       tdi,
  output logic       bit_vld,
  output logic [1:0] bit_val
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    bit_vld = 1'b0;
    bit_val = 2'h0;
  end

  // One test clock period built from system edges, so both clocks stay coordinated
  task automatic step(input logic m, input logic d, input logic look, input int hold);
    @(posedge clk);
    tms <= m;
    tdi <= d;
    repeat (15) @(posedge clk);
    tck <= 1'b1;
    bit_vld <= look;
    bit_val <= {tdo_oe_n, tdo};
    @(posedge clk);
    bit_vld <= 1'b0;
    repeat (15 + hold) @(posedge clk);
    tck <= 1'b0;
    tdi <= 1'b1; // Released line reads as its pull-up
  endtask
endmodule
`default_nettype wire

// File: sim/boundary_scan_tap_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_tap_port_tb;
  import bst_pkg::*;
  localparam logic [8:0] WALK = 9'h0F9;
  localparam logic [2:0] CODES [3] = '{BST_IR_BYPASS, BST_IR_CLAMP, BST_IR_HIGHZ};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        trst_n = 1'b0;
  logic        dbg_sel = 1'b0;
  logic        upd_accept = 1'b1;
  logic        tck, tms, tdi, tdo, tdo_oe_n, bit_vld, func_rst, pull_en, dbg_mode;
  logic [1:0]  bit_val;
  logic [7:0]  pin_in, core_o, core_oe_n, pin_o, pin_oe_n;
  logic [23:0] pre;
  logic [1:0]  exp_q[$];
  int          seed = 87872;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cycles = 0;
  bst_tap_in_t tap;

  assign tap = {tck, tms, tdi, trst_n, dbg_sel};
  always #2.5 clk = ~clk;

  bst_tap i_dut (.clk(clk), .rst(rst), .tap_i(tap), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
    .pin_in(pin_in), .core_o(core_o), .core_oe_n(core_oe_n), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n), .upd_accept(upd_accept), .func_rst(func_rst),
    .pull_en(pull_en), .dbg_mode(dbg_mode));
  bst_ctl_model i_ctl (.clk(clk), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .tck(tck), .tms(tms),
    .tdi(tdi), .bit_vld(bit_vld), .bit_val(bit_val));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // LSB first from idle; hold parks the test clock high mid-frame
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      input logic [31:0] exp, input int hold);
    i_ctl.step(1'b1, 1'b0, 1'b0, 0);
    if (ir) begin
      i_ctl.step(1'b1, 1'b0, 1'b0, 0);
    end
    i_ctl.step(1'b0, 1'b0, 1'b0, 0);
    i_ctl.step(1'b0, 1'b0, 1'b0, 0);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({1'b0, exp[i]});
      i_ctl.step(i == n - 1, din[i], 1'b1, (i == 5) ? hold : 0);
    end
    i_ctl.step(1'b1, 1'b0, 1'b0, 0);
    i_ctl.step(1'b0, 1'b0, 1'b0, 0);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (bit_vld === 1'b1) begin
      check(bit_val, (exp_q.size() > 0) ? exp_q.pop_front() : 2'h3);
    end
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    {pin_in, core_o, core_oe_n} <= 24'($random(seed));
    pre = 24'($random(seed));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    trst_n <= 1'b1;
    repeat (8) @(posedge clk);
    check({tdo_oe_n, pull_en, dbg_mode, func_rst}, 4'hC);
    $display("reset test done");
    // Stalled pin side: preload word must wait in the buffer
    upd_accept <= 1'b0;
    // Scans start from idle, so leave Test-Logic-Reset first
    i_ctl.step(1'b0, 1'b0, 1'b0, 0);
    scan(1'b1, 3, BST_IR_SAMPLE, BST_IR_CAPTURE, 0);
    scan(1'b0, 24, pre, {core_oe_n, core_o, pin_in}, 0);
    upd_accept <= 1'b1;
    scan(1'b1, 3, BST_IR_EXTEST, BST_IR_CAPTURE, 0);
    repeat (8) @(posedge clk);
    check({func_rst, pin_oe_n, pin_o}, {1'b1, pre[23:8]});
    $display("preload test done");
    for (int k = 0; k < 3; k++) begin
      scan(1'b1, 3, CODES[k], BST_IR_CAPTURE, 0);
      scan(1'b0, 2, 32'h1, 32'h2, 0);
      check({func_rst, pin_oe_n, pin_o}, (CODES[k] == BST_IR_BYPASS) ? {1'b0, core_oe_n, core_o}
        : (CODES[k] == BST_IR_CLAMP) ? {1'b1, pre[23:8]} : {1'b1, 8'hFF, core_o});
    end
    $display("bypass test done");
    trst_n <= 1'b0;
    repeat (10) @(posedge clk);
    check({func_rst, pin_oe_n}, {1'b0, core_oe_n});
    trst_n <= 1'b1;
    i_ctl.step(1'b0, 1'b0, 1'b0, 0);
    scan(1'b1, 3, BST_IR_BYPASS, BST_IR_CAPTURE, 0);
    for (int k = 0; k < 9; k++) begin
      i_ctl.step(WALK[k], 1'b0, 1'b0, 0);
    end
    scan(1'b0, 32, 32'h0, BST_ID_VALUE, 300);
    $display("tap reset test done");
    dbg_sel <= 1'b1;
    repeat (10) @(posedge clk);
    check({dbg_mode, pull_en, tdo_oe_n, func_rst}, 4'hA);
    dbg_sel <= 1'b0;
    repeat (10) @(posedge clk);
    check(pull_en, 1'b1);
    $display("debug test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
